// ==== include/vpint_pkg.sv ====
package vpint_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_IRQ = 72;
	localparam int FLAG_W = 80;
	localparam int NUM_FLAG_REGS = 5;
	localparam int NUM_PRIO_REGS = 18;
	localparam int NUM_EXT = 5;
	localparam int ADDR_W = 8;
	localparam logic [FLAG_W-1:0] IMPL_MASK = 80'h00ff_ffff_ffff_ffff_ffff;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFF_FLAG0 = 8'h08;
	localparam logic [7:0] OFF_ENABLE0 = 8'h1c;
	localparam logic [7:0] OFF_PRIO0 = 8'h30;
	localparam logic [7:0] OFF_PEND_INFO = 8'h78;
	localparam logic [7:0] OFF_CPU_STATUS = 8'h7c;
	localparam logic [7:0] OFF_CORE_CTRL = 8'h80;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int NEST_BIT = 15;
	localparam int OSC_BIT = 1;
	localparam int STK_BIT = 2;
	localparam int ADDR_ERR_BIT = 3;
	localparam int MATH_BIT = 4;
	localparam int DMA_ERR_BIT = 5;
	localparam int DIV0_BIT = 6;
	localparam int ALT_BIT = 15;
	localparam int IPL_LSB = 5;
	localparam int TOP_BIT = 3;
	localparam logic [15:0] CTRL_ONE_MASK = 16'h807e;
	localparam logic [15:0] CTRL_TWO_MASK = 16'h801f;

	// ----------------------------------------
	// Vectors and table layout
	// ----------------------------------------
	localparam logic [6:0] VEC_OSC = 7'h01;
	localparam logic [6:0] VEC_ADDR_ERR = 7'h02;
	localparam logic [6:0] VEC_STACK = 7'h03;
	localparam logic [6:0] VEC_MATH = 7'h04;
	localparam logic [6:0] VEC_DMA_ERR = 7'h05;
	localparam logic [6:0] USER_VEC_BASE = 7'h08;
	localparam logic [3:0] TRAP_LEVEL_TOP = 4'hf;
	localparam logic [2:0] IPL_ALL_MASKED = 3'h7;
	localparam logic [23:0] DEFAULT_TABLE_BASE = 24'h000004;
	localparam logic [23:0] ALT_TABLE_OFFSET = 24'h000100;
	// Request numbers of the five external inputs
	localparam int EXT_IRQ_NUM [NUM_EXT] = '{0, 20, 29, 53, 54};
endpackage : vpint_pkg

// ==== logic/vpint_ctrl.sv ====
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Thirty-three software registers in the controller
// - Control one: nesting disable plus trap flags
// - Control two: external edge polarity, alternate table
// - Sticky request flag per source, software clears
// - Per-source enable gates CPU request
// - Three-bit priority per user source
// - Latch winning vector and level into info
// - Reported new level equals pending priority; nesting disable forces its low three bits to seven
// - Bits assigned in ascending request order
// - Status bits 7..5 hold writable level
// - Level top bit read-only to software
// - Fixed trap slots one to five
// - Trap table starts 0x4, alternate 0x104
// - Alternate address is default plus 0x100
// - External three/four are requests 53/54
// - Serial errors are requests 65/66
// - DMA six/seven are requests 68/69
// - Alternate select redirects every vector fetch
// - Level seven or top bit masks users
module vpint_ctrl (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [vpint_pkg::NUM_IRQ-1:0] irq_req,
	input wire logic [vpint_pkg::NUM_EXT-1:0] ext_irq_pin,
	input wire logic osc_fail,
	input wire logic address_error,
	input wire logic stack_error,
	input wire logic math_error,
	input wire logic div_by_zero,
	input wire logic dma_error,
	input wire logic irq_ack,
	input wire logic irq_return,
	input wire logic [3:0] return_level,
	output logic irq_valid,
	output logic [6:0] irq_vector,
	output logic [3:0] irq_level,
	output logic [23:0] irq_vector_addr,
	output logic [3:0] cpu_priority_level
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] global_ctrl_one;
	logic [15:0] global_ctrl_two;
	logic [vpint_pkg::FLAG_W-1:0] flag;
	logic [vpint_pkg::FLAG_W-1:0] enable;
	logic [2:0] prio [vpint_pkg::NUM_IRQ];
	logic [10:0] pending_info_reg;
	logic [vpint_pkg::NUM_EXT-1:0] ext_s1, ext_s2, ext_s3;
	logic wr_pend, rd_pend;
	logic [vpint_pkg::ADDR_W-1:0] wr_addr, rd_addr;
	logic [vpint_pkg::FLAG_W-1:0] next_flag, hw_set;
	logic [15:0] next_ctrl_one;
	logic [31:0] rd_word;
	logic win_valid;
	logic [6:0] win_vec;
	logic [3:0] win_lvl;
	logic accept;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int n);
		hit = (a >= base) && (a < base + 8'(4 * n));
	endfunction : hit

	function automatic int reg_idx(input logic [7:0] a, input logic [7:0] base);
		reg_idx = int'((a - base) >> 2);
	endfunction : reg_idx

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	assign accept = hsel && hready && htrans[1];

	// Reads take one wait state so a read right after a write sees it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= '0;
			rd_addr <= '0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			wr_pend <= accept && hwrite;
			rd_pend <= accept && !hwrite;
			if (accept) begin
				wr_addr <= haddr[vpint_pkg::ADDR_W-1:0];
				rd_addr <= haddr[vpint_pkg::ADDR_W-1:0];
			end
			hreadyout <= !(accept && !hwrite);
			if (rd_pend) begin
				hrdata <= rd_word;
			end
			hresp <= 1'b0;
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		if (rd_addr == vpint_pkg::OFF_CTRL_ONE) begin
			rd_word[15:0] = global_ctrl_one;
		end else if (rd_addr == vpint_pkg::OFF_CTRL_TWO) begin
			rd_word[15:0] = global_ctrl_two;
		end else if (hit(rd_addr, vpint_pkg::OFF_FLAG0, vpint_pkg::NUM_FLAG_REGS)) begin
			rd_word[15:0] = flag[16 * reg_idx(rd_addr, vpint_pkg::OFF_FLAG0) +: 16];
		end else if (hit(rd_addr, vpint_pkg::OFF_ENABLE0, vpint_pkg::NUM_FLAG_REGS)) begin
			rd_word[15:0] = enable[16 * reg_idx(rd_addr, vpint_pkg::OFF_ENABLE0) +: 16];
		end else if (hit(rd_addr, vpint_pkg::OFF_PRIO0, vpint_pkg::NUM_PRIO_REGS)) begin
			for (int j = 0; j < 4; j++) begin
				rd_word[4 * j +: 3] = prio[4 * reg_idx(rd_addr, vpint_pkg::OFF_PRIO0) + j];
			end
		end else if (rd_addr == vpint_pkg::OFF_PEND_INFO) begin
			rd_word[10:0] = pending_info_reg;
		end else if (rd_addr == vpint_pkg::OFF_CPU_STATUS) begin
			rd_word[vpint_pkg::IPL_LSB +: 3] = cpu_priority_level[2:0];
		end else if (rd_addr == vpint_pkg::OFF_CORE_CTRL) begin
			rd_word[vpint_pkg::TOP_BIT] = cpu_priority_level[3];
		end
	end

	// ----------------------------------------
	// External inputs: sync then edge detect
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_s1 <= '0;
			ext_s2 <= '0;
			ext_s3 <= '0;
		end else begin
			ext_s1 <= ext_irq_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	always_comb begin
		hw_set = '0;
		hw_set[vpint_pkg::NUM_IRQ-1:0] = irq_req;
		for (int e = 0; e < vpint_pkg::NUM_EXT; e++) begin
			// Polarity bit set selects the falling edge
			if (global_ctrl_two[e] ? (ext_s3[e] && !ext_s2[e]) : (!ext_s3[e] && ext_s2[e])) begin
				hw_set[vpint_pkg::EXT_IRQ_NUM[e]] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Flags, enables, priorities
	// ----------------------------------------
	always_comb begin
		next_flag = flag;
		if (wr_pend && hit(wr_addr, vpint_pkg::OFF_FLAG0, vpint_pkg::NUM_FLAG_REGS)) begin
			next_flag[16 * reg_idx(wr_addr, vpint_pkg::OFF_FLAG0) +: 16] = hwdata[15:0];
		end
		// Hardware set wins over a software clear in the same cycle
		next_flag = (next_flag | hw_set) & vpint_pkg::IMPL_MASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag <= '0;
		end else begin
			flag <= next_flag;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable <= '0;
		end else if (wr_pend && hit(wr_addr, vpint_pkg::OFF_ENABLE0, vpint_pkg::NUM_FLAG_REGS)) begin
			enable[16 * reg_idx(wr_addr, vpint_pkg::OFF_ENABLE0) +: 16] <= hwdata[15:0];
			enable[vpint_pkg::FLAG_W-1:vpint_pkg::NUM_IRQ] <= '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < vpint_pkg::NUM_IRQ; i++) begin
				prio[i] <= 3'h0;
			end
		end else if (wr_pend && hit(wr_addr, vpint_pkg::OFF_PRIO0, vpint_pkg::NUM_PRIO_REGS)) begin
			for (int j = 0; j < 4; j++) begin
				prio[4 * reg_idx(wr_addr, vpint_pkg::OFF_PRIO0) + j] <= hwdata[4 * j +: 3];
			end
		end
	end

	// ----------------------------------------
	// Global control and trap flags
	// ----------------------------------------
	always_comb begin
		next_ctrl_one = global_ctrl_one;
		if (wr_pend && wr_addr == vpint_pkg::OFF_CTRL_ONE) begin
			next_ctrl_one = hwdata[15:0] & vpint_pkg::CTRL_ONE_MASK;
		end
		next_ctrl_one[vpint_pkg::OSC_BIT] = next_ctrl_one[vpint_pkg::OSC_BIT] | osc_fail;
		next_ctrl_one[vpint_pkg::STK_BIT] = next_ctrl_one[vpint_pkg::STK_BIT] | stack_error;
		next_ctrl_one[vpint_pkg::ADDR_ERR_BIT] = next_ctrl_one[vpint_pkg::ADDR_ERR_BIT] | address_error;
		next_ctrl_one[vpint_pkg::MATH_BIT] = next_ctrl_one[vpint_pkg::MATH_BIT] | math_error | div_by_zero;
		next_ctrl_one[vpint_pkg::DMA_ERR_BIT] = next_ctrl_one[vpint_pkg::DMA_ERR_BIT] | dma_error;
		next_ctrl_one[vpint_pkg::DIV0_BIT] = next_ctrl_one[vpint_pkg::DIV0_BIT] | div_by_zero;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_ctrl_one <= 16'h0000;
		end else begin
			global_ctrl_one <= next_ctrl_one;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			global_ctrl_two <= 16'h0000;
		end else if (wr_pend && wr_addr == vpint_pkg::OFF_CTRL_TWO) begin
			global_ctrl_two <= hwdata[15:0] & vpint_pkg::CTRL_TWO_MASK;
		end
	end

	// ----------------------------------------
	// CPU priority level
	// ----------------------------------------
	// Top bit moves only on acknowledge or return, so software cannot mask traps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_priority_level <= 4'h0;
		end else if (irq_ack && irq_valid) begin
			cpu_priority_level <= irq_level;
			if (global_ctrl_one[vpint_pkg::NEST_BIT]) begin
				cpu_priority_level[2:0] <= vpint_pkg::IPL_ALL_MASKED;
			end
		end else if (irq_return) begin
			cpu_priority_level <= return_level;
		end else if (wr_pend && wr_addr == vpint_pkg::OFF_CPU_STATUS && !global_ctrl_one[vpint_pkg::NEST_BIT]) begin
			cpu_priority_level[2:0] <= hwdata[vpint_pkg::IPL_LSB +: 3];
		end
	end

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	always_comb begin
		win_valid = 1'b0;
		win_vec = 7'h00;
		win_lvl = 4'h0;
		// Descending scan with >= leaves the lowest request on a tie
		for (int i = vpint_pkg::NUM_IRQ - 1; i >= 0; i--) begin
			if (flag[i] && enable[i] && !cpu_priority_level[3] && prio[i] > cpu_priority_level[2:0]
				&& {1'b0, prio[i]} >= win_lvl) begin
				win_valid = 1'b1;
				win_vec = vpint_pkg::USER_VEC_BASE + 7'(i);
				win_lvl = {1'b0, prio[i]};
			end
		end
		// Traps outrank users; lower slot wins, and the stack bit sits below its slot
		for (int t = vpint_pkg::DMA_ERR_BIT; t >= vpint_pkg::OSC_BIT; t--) begin
			if (global_ctrl_one[t] && !(t == vpint_pkg::STK_BIT && global_ctrl_one[vpint_pkg::ADDR_ERR_BIT])) begin
				win_valid = 1'b1;
				case (t)
					vpint_pkg::OSC_BIT: win_vec = vpint_pkg::VEC_OSC;
					vpint_pkg::STK_BIT: win_vec = vpint_pkg::VEC_STACK;
					vpint_pkg::ADDR_ERR_BIT: win_vec = vpint_pkg::VEC_ADDR_ERR;
					vpint_pkg::MATH_BIT: win_vec = vpint_pkg::VEC_MATH;
					default: win_vec = vpint_pkg::VEC_DMA_ERR;
				endcase
			end
		end
		if (win_valid && win_vec < vpint_pkg::USER_VEC_BASE) begin
			win_lvl = vpint_pkg::TRAP_LEVEL_TOP - win_vec[3:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_valid <= 1'b0;
			irq_vector <= 7'h00;
			irq_level <= 4'h0;
			irq_vector_addr <= 24'h000000;
			pending_info_reg <= 11'h000;
		end else begin
			irq_valid <= win_valid;
			irq_vector <= win_vec;
			irq_level <= win_lvl;
			pending_info_reg <= {win_lvl, win_vec};
			irq_vector_addr <= vpint_pkg::DEFAULT_TABLE_BASE + {16'h0000, win_vec, 1'b0}
				+ (global_ctrl_two[vpint_pkg::ALT_BIT] ? vpint_pkg::ALT_TABLE_OFFSET : 24'h000000);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_ext0_rise;
		!ext_irq_pin[0] && !global_ctrl_two[0] ##1 ext_irq_pin[0] [*3];
	endsequence

	a_ext_edge_flag: assert property (s_ext0_rise |-> ##[0:1] flag[0])
		else $error("rising edge on external input 0 did not set its flag");
	a_flag_sticky: assert property (irq_req[46] |=> flag[46])
		else $error("request did not set its flag");
	a_reserved_zero: assert property (flag[vpint_pkg::FLAG_W-1:vpint_pkg::NUM_IRQ] == '0)
		else $error("reserved request flag raised");
	a_user_enabled: assert property (irq_valid && irq_vector >= vpint_pkg::USER_VEC_BASE
		|-> $past(enable[win_vec - vpint_pkg::USER_VEC_BASE]))
		else $error("disabled source presented");
	a_level_mask: assert property (cpu_priority_level[3] && !(|global_ctrl_one[6:1]) |=> !irq_valid)
		else $error("user interrupt passed a masking level");
	a_info_match: assert property (pending_info_reg == {irq_level, irq_vector})
		else $error("pending info differs from presented vector");
	a_ack_level: assert property (irq_ack && irq_valid && !global_ctrl_one[vpint_pkg::NEST_BIT]
		|=> cpu_priority_level == $past(irq_level))
		else $error("acknowledge did not load the pending level");
	a_alt_addr: assert property (global_ctrl_two[vpint_pkg::ALT_BIT] && $stable(global_ctrl_two) && irq_valid
		&& irq_vector == 7'h36 |-> irq_vector_addr == 24'h000170)
		else $error("alternate table address wrong");
	a_top_ro: assert property (wr_pend && !irq_ack && !irq_return |=> $stable(cpu_priority_level[3]))
		else $error("software changed the level top bit");
	a_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
endmodule : vpint_ctrl
`default_nettype wire

// ==== tb/vpint_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module vpint_core_model #(
	parameter int RET_WAIT = 10
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ack_en,
	input wire logic irq_valid,
	input wire logic [3:0] cpu_priority_level,
	output logic irq_ack,
	output logic irq_return,
	output logic [3:0] return_level
);
	logic busy;
	logic [3:0] saved;
	int cnt;
	// Return level is junk outside its pulse, so nothing may latch it early
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ack <= 1'b0;
			irq_return <= 1'b0;
			return_level <= 4'h0;
			busy <= 1'b0;
			saved <= 4'h0;
			cnt <= 0;
		end else begin
			irq_ack <= 1'b0;
			irq_return <= 1'b0;
			return_level <= ~saved;
			if (!busy && !irq_ack && ack_en && irq_valid) begin
				irq_ack <= 1'b1;
				saved <= cpu_priority_level;
				busy <= 1'b1;
				cnt <= 0;
			end else if (busy) begin
				cnt <= cnt + 1;
				if (cnt == RET_WAIT) begin
					irq_return <= 1'b1;
					return_level <= saved;
					busy <= 1'b0;
				end
			end
		end
	end
endmodule : vpint_core_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq_ack, irq_return, irq_valid;
	logic ack_en = 1'b0;
	logic [vpint_pkg::NUM_IRQ-1:0] irq_req = '0;
	logic [4:0] ext_irq_pin = 5'h0;
	logic [5:0] trap = 6'h0;
	logic [3:0] return_level, irq_level, cpu_priority_level;
	logic [6:0] irq_vector;
	logic [23:0] irq_vector_addr;
	logic [6:0] tv [6] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h04, 7'h05};
	logic [15:0] tc [6] = '{16'h0002, 16'h0008, 16'h0004, 16'h0010, 16'h0050, 16'h0020};
	logic [7:0] ro [9] = '{8'h00, 8'h04, 8'h08, 8'h1c, 8'h30, 8'h78, 8'h7c, 8'h80, 8'hf0};
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;

	vpint_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req), .ext_irq_pin(ext_irq_pin),
		.osc_fail(trap[0]), .address_error(trap[1]), .stack_error(trap[2]), .math_error(trap[3]),
		.div_by_zero(trap[4]), .dma_error(trap[5]), .irq_ack(irq_ack), .irq_return(irq_return),
		.return_level(return_level), .irq_valid(irq_valid), .irq_vector(irq_vector),
		.irq_level(irq_level), .irq_vector_addr(irq_vector_addr), .cpu_priority_level(cpu_priority_level));
	vpint_core_model core (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en), .irq_valid(irq_valid),
		.cpu_priority_level(cpu_priority_level), .irq_ack(irq_ack), .irq_return(irq_return),
		.return_level(return_level));

	initial begin
		forever #10 hclk = ~hclk;
	end

	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge hclk);
	endtask : tick

	// One single word transfer; waits on hready only, never on a fixed count
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk("register", exp, r);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rdc

	task irq(input logic v, input logic [6:0] vec, input logic [3:0] lvl, input logic [23:0] adr);
		chk("irq_valid", {31'h0, v}, {31'h0, irq_valid});
		chk("irq_vector", {25'h0, vec}, {25'h0, irq_vector});
		chk("irq_level", {28'h0, lvl}, {28'h0, irq_level});
		chk("irq_vector_addr", {8'h0, adr}, {8'h0, irq_vector_addr});
	endtask : irq

	task run_req(input int n, input logic [6:0] vec, input logic [23:0] adr);
		logic [7:0] fo;
		fo = vpint_pkg::OFF_FLAG0 + 8'(4 * (n / 16));
		wr(vpint_pkg::OFF_ENABLE0 + 8'(4 * (n / 16)), 32'h1 << (n % 16));
		wr(vpint_pkg::OFF_PRIO0 + 8'(4 * (n / 4)), 32'h1 << (4 * (n % 4)));
		irq_req[n] <= 1'b1;
		tick(1);
		irq_req <= '0;
		tick(4);
		rdc(fo, 32'h1 << (n % 16));
		irq(1'b1, vec, 4'h1, adr);
		wr(fo, 32'h0);
		wr(fo + 8'h14, 32'h0);
		tick(3);
		chk("irq_valid", 32'h0, {31'h0, irq_valid});
	endtask : run_req

	initial begin
		tick(10);
		hresetn <= 1'b1;
		tick(1);
		for (int i = 0; i < 9; i++) rdc(ro[i], 32'h0);
		wr(vpint_pkg::OFF_CTRL_TWO, 32'h8000);
		run_req(46, 7'd54, 24'h000170);
		wr(vpint_pkg::OFF_CTRL_TWO, 32'h0);
		run_req(46, 7'd54, 24'h000070);
		run_req(53, 7'd61, 24'h00007e);
		run_req(54, 7'd62, 24'h000080);
		run_req(65, 7'd73, 24'h000096);
		run_req(66, 7'd74, 24'h000098);
		run_req(68, 7'd76, 24'h00009c);
		run_req(69, 7'd77, 24'h00009e);
		wr(8'h2c, 32'hffff);
		rdc(8'h2c, 32'h00ff);
		wr(8'h2c, 32'h0);
		wr(8'h18, 32'hffff);
		rdc(8'h18, 32'h00ff);
		wr(8'h18, 32'h0);
		// Two sources raced: priority first, then natural order
		irq_req[53] <= 1'b1;
		irq_req[54] <= 1'b1;
		tick(1);
		irq_req <= '0;
		wr(8'h64, 32'h0630);
		tick(3);
		chk("irq_valid", 32'h0, {31'h0, irq_valid});
		wr(8'h28, 32'h0060);
		tick(3);
		irq(1'b1, 7'd62, 4'h6, 24'h000080);
		wr(8'h64, 32'h0330);
		tick(3);
		irq(1'b1, 7'd61, 4'h3, 24'h00007e);
		rdc(vpint_pkg::OFF_PEND_INFO, 32'h01bd);
		wr(vpint_pkg::OFF_CTRL_TWO, 32'h8000);
		tick(3);
		rdc(vpint_pkg::OFF_CTRL_TWO, 32'h8000);
		irq(1'b1, 7'd61, 4'h3, 24'h00017e);
		ack_en <= 1'b1;
		for (int i = 0; i < 50 && irq_ack !== 1'b1; i++) tick(1);
		ack_en <= 1'b0;
		tick(2);
		chk("cpu_priority_level", 32'h3, {28'h0, cpu_priority_level});
		tick(14);
		chk("cpu_priority_level", 32'h0, {28'h0, cpu_priority_level});
		wr(vpint_pkg::OFF_CPU_STATUS, 32'h0060);
		tick(3);
		chk("irq_valid", 32'h0, {31'h0, irq_valid});
		wr(vpint_pkg::OFF_CPU_STATUS, 32'h0040);
		tick(3);
		irq(1'b1, 7'd61, 4'h3, 24'h00017e);
		wr(vpint_pkg::OFF_CPU_STATUS, 32'h00e0);
		wr(vpint_pkg::OFF_CORE_CTRL, 32'h0008);
		tick(3);
		rdc(vpint_pkg::OFF_CPU_STATUS, 32'h00e0);
		rdc(vpint_pkg::OFF_CORE_CTRL, 32'h0);
		chk("irq_valid", 32'h0, {31'h0, irq_valid});
		wr(vpint_pkg::OFF_CPU_STATUS, 32'h0);
		// Traps beat the pending user source, with the level written back to zero
		for (int i = 0; i < 6; i++) begin
			trap[i] <= 1'b1;
			tick(1);
			trap <= 6'h0;
			tick(4);
			rdc(vpint_pkg::OFF_CTRL_ONE, {16'h0, tc[i]});
			irq(1'b1, tv[i], 4'hf - 4'(tv[i]), 24'h000104 + 24'(2 * tv[i]));
			wr(vpint_pkg::OFF_CTRL_ONE, 32'h0);
		end
		// Address and stack errors together: the lower slot wins
		trap <= 6'h06;
		tick(1);
		trap <= 6'h0;
		tick(4);
		irq(1'b1, 7'd2, 4'hd, 24'h000108);
		// Nesting disabled: acknowledged trap sets the top bit, level write ignored
		wr(vpint_pkg::OFF_CTRL_ONE, 32'h8000);
		trap[0] <= 1'b1;
		tick(1);
		trap <= 6'h0;
		tick(2);
		ack_en <= 1'b1;
		for (int i = 0; i < 50 && irq_ack !== 1'b1; i++) tick(1);
		ack_en <= 1'b0;
		wr(vpint_pkg::OFF_CTRL_ONE, 32'h8000);
		wr(vpint_pkg::OFF_CPU_STATUS, 32'h0040);
		chk("irq_valid", 32'h0, {31'h0, irq_valid});
		chk("cpu_priority_level", 32'hf, {28'h0, cpu_priority_level});
		rdc(vpint_pkg::OFF_CPU_STATUS, 32'h00e0);
		rdc(vpint_pkg::OFF_CORE_CTRL, 32'h0008);
		wr(vpint_pkg::OFF_CTRL_ONE, 32'h0);
		tick(3);
		chk("cpu_priority_level", 32'h0, {28'h0, cpu_priority_level});
		irq(1'b1, 7'd61, 4'h3, 24'h00017e);
		wr(vpint_pkg::OFF_CTRL_TWO, 32'h0010);
		wr(8'h14, 32'h0);
		ext_irq_pin <= 5'h19;
		tick(6);
		rdc(8'h14, 32'h0020);
		rdc(vpint_pkg::OFF_FLAG0, 32'h0001);
		ext_irq_pin <= 5'h08;
		tick(6);
		rdc(8'h14, 32'h0060);
		rdc(vpint_pkg::OFF_FLAG0, 32'h0001);
		stop_test();
	end
endmodule : tb
`default_nettype wire
